/* wpg_pkg.sv */
// Constants and types shared by the waveform pattern generator files
package wpg_pkg;
   localparam int WPG_CHANNELS      = 8;
   localparam int WPG_MAX_FRAMES    = 512;
   localparam int WPG_IDX_W         = 9;
   localparam int WPG_FRAMES_W      = 10;
   localparam int WPG_DIV_W         = 16;
   localparam int WPG_ADDR_W        = 12;
   localparam int WPG_FIFO_DEPTH    = 8;
   localparam int WPG_CLK_PERIOD_PS = 8000;
   localparam int WPG_MIN_TICK_NS   = 100;
   localparam int WPG_MIN_TICK_CYC  = (WPG_MIN_TICK_NS * 1000 + WPG_CLK_PERIOD_PS - 1) / WPG_CLK_PERIOD_PS;

   localparam logic [11:0] WPG_REG_CTRL    = 12'h000;
   localparam logic [11:0] WPG_REG_CHAN_EN = 12'h004;
   localparam logic [11:0] WPG_REG_STATIC  = 12'h008;
   localparam logic [11:0] WPG_REG_FRAMES  = 12'h00C;
   localparam logic [11:0] WPG_REG_DIV     = 12'h010;
   localparam logic [11:0] WPG_REG_RUN     = 12'h014;
   localparam logic [11:0] WPG_REG_STATUS  = 12'h018;

   localparam int WPG_PAT_SEL_BIT    = 11;
   localparam int WPG_CTRL_CONT_BIT  = 0;
   localparam int WPG_CTRL_EXT_BIT   = 1;
   localparam int WPG_CTRL_GATE_BIT  = 2;
   localparam int WPG_RUN_CMD_BIT    = 0;
   localparam int WPG_STAT_PLAY_BIT  = 0;
   localparam int WPG_STAT_STOP_BIT  = 1;
   localparam int WPG_STAT_IDX_LSB   = 16;

   localparam logic             WPG_CONT_RST    = 1'h1;
   localparam logic [7:0]       WPG_CHAN_EN_RST = 8'hFF;
   localparam logic [7:0]       WPG_STATIC_RST  = 8'h00;
   localparam logic [9:0]       WPG_FRAMES_RST  = 10'h200;
   localparam logic [15:0]      WPG_DIV_RST     = 16'h000D;

   typedef enum logic [0:0] {WPG_IDLE, WPG_PLAY} wpg_mode_t;

   typedef struct packed {
      logic [WPG_IDX_W-1:0]    idx;
      logic [WPG_CHANNELS-1:0] levels;
   } wpg_pat_wr_t;

   typedef struct packed {
      wpg_mode_t               mode;
      logic                    cont;
      logic                    ext_en;
      logic                    ext_gate;
      logic [WPG_CHANNELS-1:0] chan_en;
      logic [WPG_CHANNELS-1:0] static_lvl;
      logic [WPG_FRAMES_W-1:0] frames;
      logic [WPG_DIV_W-1:0]    div;
      logic [WPG_DIV_W-1:0]    cnt;
      logic [WPG_IDX_W-1:0]    idx;
      logic [WPG_CHANNELS-1:0] frame;
      logic                    stop_pend;
      logic                    trig_prev;
      logic                    rd_done;
      logic [31:0]             rdata;
      logic [WPG_CHANNELS-1:0] wave;
   } wpg_core_t;

   // Byte-lane merge for register writes
   function automatic logic [31:0] wpg_merge(input logic [31:0] old_word, input logic [31:0] new_word,
                                             input logic [3:0] be);
      logic [31:0] res;
      res = old_word;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_word[b*8 +: 8];
         end
      end
      return res;
   endfunction : wpg_merge
endpackage : wpg_pkg

/* wpg_sync2.sv */
// Two-flop synchroniser for the external trigger or clock enable pin
`timescale 1ns/100ps
module wpg_sync2
   import wpg_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   input  wire logic async_in,
   output logic      sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
   } wpg_sync_t;

   wpg_sync_t st;
   wpg_sync_t next_st;

   always_comb begin
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.s2;
endmodule : wpg_sync2

/* wpg_fifo.sv */
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/100ps
module wpg_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [PW:0]   count;
   } wpg_fifo_state_t;

   wpg_fifo_state_t  st;
   wpg_fifo_state_t  next_st;
   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic             push;
   logic             pop;

   // Depth must be a power of two so the pointers wrap by themselves
   assign in_ready_out  = st.count != (PW+1)'(DEPTH);
   assign out_valid_out = st.count != '0;
   assign out_data_out  = store[st.rd];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_comb begin
      next_st       = st;
      next_st.wr    = push ? st.wr + 1'b1 : st.wr;
      next_st.rd    = pop ? st.rd + 1'b1 : st.rd;
      next_st.count = st.count + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         store[st.wr] <= in_data_in;
      end
   end
endmodule : wpg_fifo

/* wpg_top.sv */
// Eight-channel waveform pattern generator with Avalon-MM register slave
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
module wpg_top
   import wpg_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic                    sys_rst_in,
   input  wire logic [WPG_ADDR_W-1:0]   avs_address_in,
   input  wire logic                    avs_read_in,
   input  wire logic                    avs_write_in,
   input  wire logic [31:0]             avs_writedata_in,
   input  wire logic [3:0]              avs_byteenable_in,
   output logic [31:0]                  avs_readdata_out,
   output logic                         avs_waitrequest_out,
   input  wire logic                    external_trigger_clock_enable_in,
   output logic [WPG_CHANNELS-1:0]      wave_out,
   output logic                         playing_out
);
   localparam logic [WPG_DIV_W-1:0] MIN_TICK = WPG_DIV_W'(WPG_MIN_TICK_CYC);

   wpg_core_t               st;
   wpg_core_t               next_st;
   logic [WPG_CHANNELS-1:0] pattern_mem [0:WPG_MAX_FRAMES-1];
   logic                    trig_sync;
   logic                    pat_sel;
   logic [WPG_IDX_W-1:0]    bus_idx;
   logic                    reg_wr;
   logic [31:0]             reg_word;
   logic [31:0]             wd;
   logic                    sw_run;
   logic                    ext_run;
   logic                    run_cmd;
   logic                    gate_ok;
   logic [WPG_DIV_W-1:0]    period;
   logic                    last;
   logic                    tick;
   logic [WPG_CHANNELS-1:0] mem_frame;
   wpg_pat_wr_t             fifo_in;
   wpg_pat_wr_t             fifo_out;
   logic                    fifo_in_valid;
   logic                    fifo_in_ready;
   logic                    fifo_out_valid;
   logic                    fifo_out_ready;

   wpg_sync2 u_sync (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .async_in   (external_trigger_clock_enable_in),
      .sync_out   (trig_sync)
   );

   // Pattern writes queue here so the frame store never changes under playback
   wpg_fifo #(
      .WIDTH ($bits(wpg_pat_wr_t)),
      .DEPTH (WPG_FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .sys_rst_in    (sys_rst_in),
      .in_valid_in   (fifo_in_valid),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (fifo_in),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_out_ready),
      .out_data_out  (fifo_out)
   );

   assign pat_sel        = avs_address_in[WPG_PAT_SEL_BIT];
   assign bus_idx        = avs_address_in[WPG_IDX_W+1:2];
   assign reg_wr         = avs_write_in && !avs_read_in && !pat_sel;
   assign fifo_in_valid  = avs_write_in && !avs_read_in && pat_sel && avs_byteenable_in[0];
   assign fifo_in.idx    = bus_idx;
   assign fifo_in.levels = avs_writedata_in[WPG_CHANNELS-1:0];
   assign fifo_out_ready = st.mode == WPG_IDLE;
   assign mem_frame      = pattern_mem[st.idx];

   // Reads wait one cycle; pattern writes wait only while the queue is full
   assign avs_waitrequest_out = (avs_read_in && !st.rd_done) || (fifo_in_valid && !fifo_in_ready);
   assign avs_readdata_out    = st.rdata;
   assign wave_out            = st.wave;
   assign playing_out         = st.mode == WPG_PLAY;

   always_ff @(posedge clk_in) begin
      if (fifo_out_valid && fifo_out_ready) begin
         pattern_mem[fifo_out.idx] <= fifo_out.levels;
      end
   end

   always_comb begin
      case (avs_address_in)
         WPG_REG_CTRL: begin
            reg_word = {29'h0, st.ext_gate, st.ext_en, st.cont};
         end
         WPG_REG_CHAN_EN: begin
            reg_word = {24'h0, st.chan_en};
         end
         WPG_REG_STATIC: begin
            reg_word = {24'h0, st.static_lvl};
         end
         WPG_REG_FRAMES: begin
            reg_word = {22'h0, st.frames};
         end
         WPG_REG_DIV: begin
            reg_word = {16'h0, st.div};
         end
         WPG_REG_STATUS: begin
            reg_word = {7'h0, st.idx, 14'h0, st.stop_pend, st.mode == WPG_PLAY};
         end
         default: begin
            reg_word = pat_sel ? {24'h0, pattern_mem[bus_idx]} : 32'h0000_0000;
         end
      endcase
   end

   assign wd      = wpg_merge(reg_word, avs_writedata_in, avs_byteenable_in);
   assign sw_run  = reg_wr && avs_address_in == WPG_REG_RUN && avs_byteenable_in[0]
                    && avs_writedata_in[WPG_RUN_CMD_BIT];
   // In trigger mode each rising edge of the pin is one run command
   assign ext_run = st.ext_en && !st.ext_gate && trig_sync && !st.trig_prev;
   assign run_cmd = sw_run || ext_run;
   // In clock-enable mode the pattern clock only counts while the pin is high
   assign gate_ok = !(st.ext_en && st.ext_gate) || trig_sync;
   // Too small a divider is raised to the 10 MHz limit
   assign period  = (st.div < MIN_TICK) ? MIN_TICK : st.div;
   assign last    = st.idx == WPG_IDX_W'(st.frames - 10'h001);
   assign tick    = st.mode == WPG_PLAY && gate_ok && st.cnt == period - 16'h0001;

   always_comb begin
      next_st           = st;
      next_st.trig_prev = trig_sync;
      next_st.rd_done   = avs_read_in && !st.rd_done;
      if (avs_read_in && !st.rd_done) begin
         next_st.rdata = reg_word;
      end
      if (reg_wr) begin
         case (avs_address_in)
            WPG_REG_CTRL: begin
               next_st.cont     = wd[WPG_CTRL_CONT_BIT];
               next_st.ext_en   = wd[WPG_CTRL_EXT_BIT];
               next_st.ext_gate = wd[WPG_CTRL_GATE_BIT];
            end
            WPG_REG_CHAN_EN: begin
               next_st.chan_en = wd[WPG_CHANNELS-1:0];
            end
            WPG_REG_STATIC: begin
               next_st.static_lvl = wd[WPG_CHANNELS-1:0];
            end
            WPG_REG_FRAMES: begin
               // Length is fixed while a pattern plays; 0 becomes 1, above 512 becomes 512
               if (st.mode == WPG_IDLE) begin
                  if (wd[WPG_FRAMES_W-1:0] == 10'h000) begin
                     next_st.frames = 10'h001;
                  end else if (wd[WPG_FRAMES_W-1:0] > WPG_FRAMES_RST) begin
                     next_st.frames = WPG_FRAMES_RST;
                  end else begin
                     next_st.frames = wd[WPG_FRAMES_W-1:0];
                  end
               end
            end
            WPG_REG_DIV: begin
               next_st.div = wd[WPG_DIV_W-1:0];
            end
            default: begin
               next_st.div = st.div;
            end
         endcase
      end
      case (st.mode)
         WPG_IDLE: begin
            next_st.cnt = '0;
            if (run_cmd) begin
               next_st.mode      = WPG_PLAY;
               next_st.idx       = '0;
               next_st.stop_pend = 1'b0;
            end
         end
         WPG_PLAY: begin
            if (gate_ok) begin
               next_st.cnt = tick ? '0 : st.cnt + 16'h0001;
            end
            // A second command before the end cancels the pending stop
            if (run_cmd && st.cont) begin
               next_st.stop_pend = !st.stop_pend;
            end
            if (tick) begin
               next_st.frame = mem_frame;
               if (last) begin
                  next_st.idx = '0;
                  if (!st.cont || next_st.stop_pend) begin
                     next_st.mode      = WPG_IDLE;
                     next_st.stop_pend = 1'b0;
                  end
               end else begin
                  next_st.idx = st.idx + 9'h001;
               end
            end
         end
         default: begin
            next_st.mode = WPG_IDLE;
         end
      endcase
      // Enabled channels follow the pattern, disabled ones their static level
      next_st.wave = (next_st.frame & next_st.chan_en) | (next_st.static_lvl & ~next_st.chan_en);
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st            <= '0;
         st.mode       <= WPG_IDLE;
         st.cont       <= WPG_CONT_RST;
         st.chan_en    <= WPG_CHAN_EN_RST;
         st.static_lvl <= WPG_STATIC_RST;
         st.frames     <= WPG_FRAMES_RST;
         st.div        <= WPG_DIV_RST;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_last_tick;
      tick && last;
   endsequence

   sequence s_start;
      st.mode == WPG_IDLE && run_cmd;
   endsequence

   property p_wave_channels;
      tick |=> ((wave_out ^ $past(mem_frame)) & st.chan_en) == 8'h00;
   endproperty
   a_wave_channels: assert property (p_wave_channels) else $error("enabled channels miss frame");

   property p_frames_bound;
      st.frames != 10'h000 && st.frames <= WPG_FRAMES_RST && (!playing_out || st.idx < st.frames);
   endproperty
   a_frames_bound: assert property (p_frames_bound) else $error("frame index or count out of range");

   property p_tick_rate;
      tick |=> !tick [*8];
   endproperty
   a_tick_rate: assert property (p_tick_rate) else $error("pattern clock faster than limit");

   property p_tick_count;
      tick |-> st.cnt >= MIN_TICK - 16'h0001;
   endproperty
   a_tick_count: assert property (p_tick_count) else $error("tick before minimum count");

   property p_disabled_static;
      ((wave_out ^ st.static_lvl) & ~st.chan_en) == 8'h00;
   endproperty
   a_disabled_static: assert property (p_disabled_static) else $error("disabled channel not static");

   property p_cont_wrap;
      s_last_tick and st.cont && !run_cmd && !st.stop_pend |=> playing_out && st.idx == 9'h000;
   endproperty
   a_cont_wrap: assert property (p_cont_wrap) else $error("continuous pattern did not wrap");

   property p_cont_toggle;
      playing_out && st.cont && run_cmd && !tick |=> st.stop_pend != $past(st.stop_pend);
   endproperty
   a_cont_toggle: assert property (p_cont_toggle) else $error("run command did not toggle stop");

   property p_single_end;
      s_last_tick and !st.cont |=> !playing_out;
   endproperty
   a_single_end: assert property (p_single_end) else $error("single shot did not stop");

   property p_start;
      s_start |=> playing_out && st.idx == 9'h000 && st.cnt == 16'h0000;
   endproperty
   a_start: assert property (p_start) else $error("run command did not start at frame zero");

   property p_gate_hold;
      playing_out && st.ext_en && st.ext_gate && !trig_sync |=> $stable(st.cnt) && $stable(st.idx);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("pattern advanced while gated off");

   property p_advance;
      tick && !last |=> st.idx == $past(st.idx) + 9'h001;
   endproperty
   a_advance: assert property (p_advance) else $error("frame index did not advance");

   property p_read_answer;
      avs_read_in && !st.rd_done |=> !avs_waitrequest_out || !avs_read_in;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered in one cycle");

   // Read data are latched on the wait cycle and stand on the answering one
   property p_read_wait;
      avs_read_in && !st.rd_done |-> avs_waitrequest_out;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read answered without a wait state");

   property p_read_data;
      avs_read_in && st.rd_done |-> avs_readdata_out == $past(reg_word);
   endproperty
   a_read_data: assert property (p_read_data) else $error("read data not from the addressed register");

   property p_reg_write_nowait;
      avs_write_in && !avs_read_in && !pat_sel |-> !avs_waitrequest_out;
   endproperty
   a_reg_write_nowait: assert property (p_reg_write_nowait) else $error("register write stalled");

   property p_queue_wait;
      fifo_in_valid && !fifo_in_ready |-> avs_waitrequest_out;
   endproperty
   a_queue_wait: assert property (p_queue_wait) else $error("pattern write taken while queue full");

   // The frame store must not change under a running pattern
   property p_pattern_frozen;
      playing_out && $past(playing_out) && $stable(st.idx) |-> $stable(mem_frame);
   endproperty
   a_pattern_frozen: assert property (p_pattern_frozen) else $error("frame store changed during play");

   property p_frames_locked;
      playing_out |=> $stable(st.frames);
   endproperty
   a_frames_locked: assert property (p_frames_locked) else $error("frame count changed during play");

   property p_count_step;
      playing_out && gate_ok && !tick |=> st.cnt == $past(st.cnt) + 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("pattern clock count did not step");

   property p_idle_stays;
      !playing_out && !run_cmd |=> !playing_out && $stable(st.idx);
   endproperty
   a_idle_stays: assert property (p_idle_stays) else $error("idle pattern moved without a command");

   property p_stop_at_end;
      $fell(playing_out) |-> $past(tick) && $past(last);
   endproperty
   a_stop_at_end: assert property (p_stop_at_end) else $error("pattern stopped before its last frame");

   property p_single_busy;
      playing_out && !st.cont && !(tick && last) |=> playing_out;
   endproperty
   a_single_busy: assert property (p_single_busy) else $error("single shot ended early");

   property p_trigger_start;
      st.ext_en && !st.ext_gate && $rose(trig_sync) && !playing_out |=> playing_out;
   endproperty
   a_trigger_start: assert property (p_trigger_start) else $error("pin edge did not start the pattern");

   property p_wrap_zero;
      s_last_tick |=> st.idx == 9'h000;
   endproperty
   a_wrap_zero: assert property (p_wrap_zero) else $error("frame index did not return to zero");
endmodule : wpg_top

/* wpg_target.sv */
// Target-side model: watches the eight channels and drives the trigger pin
`timescale 1ns/100ps
module wpg_target
   import wpg_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic [WPG_CHANNELS-1:0] wave_in,
   output logic                         pin_out
);
   logic [WPG_CHANNELS-1:0] last;
   int                      changes;

   initial begin
      pin_out = 1'b0;
      changes = 0;
      last    = '0;
   end

   // Any change on any channel counts, so a stopped pattern must stay silent
   always @(posedge clk_in) begin
      if (wave_in !== last) begin
         changes++;
      end
      last <= wave_in;
   end

   // Pin is only moved just after an edge, as a real driver would
   task automatic set_pin(input logic v);
      @(posedge clk_in);
      pin_out <= v;
   endtask : set_pin
endmodule : wpg_target

/* tb.sv */
// Self-checking testbench for the waveform pattern generator
`timescale 1ns/100ps
module tb;
   import wpg_pkg::*;
   logic                    clk_in;
   logic                    sys_rst_in;
   logic [WPG_ADDR_W-1:0]   adr;
   logic                    rd;
   logic                    wr;
   logic [31:0]             wdat;
   logic [3:0]              be;
   logic [31:0]             rdat;
   logic                    wait_req;
   logic                    pin;
   logic [WPG_CHANNELS-1:0] wave;
   logic                    playing;
   logic [31:0]             d;
   int                      fails;
   int                      compares;
   int                      n;
   logic [7:0]              pat [4] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0};

   wpg_top i_wpg_top (
      .clk_in                           (clk_in),
      .sys_rst_in                       (sys_rst_in),
      .avs_address_in                   (adr),
      .avs_read_in                      (rd),
      .avs_write_in                     (wr),
      .avs_writedata_in                 (wdat),
      .avs_byteenable_in                (be),
      .avs_readdata_out                 (rdat),
      .avs_waitrequest_out              (wait_req),
      .external_trigger_clock_enable_in (pin),
      .wave_out                         (wave),
      .playing_out                      (playing)
   );

   wpg_target u_target (
      .clk_in  (clk_in),
      .wave_in (wave),
      .pin_out (pin)
   );

   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic bus_write(input logic [11:0] a, input logic [31:0] v);
      adr  <= a;
      wdat <= v;
      wr   <= 1'b1;
      do @(posedge clk_in); while (wait_req !== 1'b0);
      wr <= 1'b0;
      @(posedge clk_in);
   endtask : bus_write

   task automatic bus_read(input logic [11:0] a, output logic [31:0] v);
      adr <= a;
      rd  <= 1'b1;
      do @(posedge clk_in); while (wait_req !== 1'b0);
      v = rdat;
      rd <= 1'b0;
      @(posedge clk_in);
   endtask : bus_read

   task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
      bus_read(a, d);
      check(d, exp);
   endtask : rd_check

   task automatic tick_check(input int k, input logic [7:0] exp);
      repeat (k) @(posedge clk_in);
      #1;
      check({24'h0, wave}, {24'h0, exp});
   endtask : tick_check

   // Bounded wait; running out shows up as a failed compare
   task automatic wait_lvl(input logic v, input int lim);
      n = 0;
      while (playing !== v && n < lim) begin
         @(posedge clk_in);
         n++;
      end
      #1;
      check({31'h0, playing}, {31'h0, v});
   endtask : wait_lvl

   task automatic stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (20000) @(posedge clk_in);
      fails++;
      stop_test();
   end

   initial begin
      fails      = 0;
      compares   = 0;
      sys_rst_in = 1'b1;
      adr        = '0;
      rd         = 1'b0;
      wr         = 1'b0;
      wdat       = '0;
      be         = 4'hF;
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      // Reset values and refused places
      check({24'h0, wave}, 32'h0);
      rd_check(WPG_REG_CTRL, 32'h1);
      rd_check(WPG_REG_CHAN_EN, 32'hFF);
      rd_check(WPG_REG_STATIC, 32'h0);
      rd_check(WPG_REG_FRAMES, 32'h200);
      rd_check(WPG_REG_DIV, 32'hD);
      rd_check(WPG_REG_RUN, 32'h0);
      rd_check(WPG_REG_STATUS, 32'h0);
      bus_write(12'h01C, 32'hFFFF_FFFF);
      rd_check(12'h01C, 32'h0);
      // Shared pattern for all channels
      for (int i = 0; i < 4; i++) begin
         bus_write(12'h800 + 12'(i * 4), {24'h0, pat[i]});
      end
      rd_check(12'h80C, 32'hF0);
      // Frame count limits and lane masking
      bus_write(WPG_REG_FRAMES, 32'h0);
      rd_check(WPG_REG_FRAMES, 32'h1);
      bus_write(WPG_REG_FRAMES, 32'h3FF);
      rd_check(WPG_REG_FRAMES, 32'h200);
      be <= 4'h2;
      bus_write(WPG_REG_STATIC, 32'hFF);
      be <= 4'hF;
      rd_check(WPG_REG_STATIC, 32'h0);
      // Single shot with a divider below the 10 MHz floor; second run ignored
      bus_write(WPG_REG_CTRL, 32'h0);
      bus_write(WPG_REG_FRAMES, 32'h2);
      bus_write(WPG_REG_DIV, 32'h1);
      bus_write(WPG_REG_RUN, 32'h1);
      #1;
      check({31'h0, playing}, 32'h1);
      bus_write(WPG_REG_RUN, 32'h1);
      tick_check(10, pat[0]);
      tick_check(13, pat[1]);
      check({31'h0, playing}, 32'h0);
      // Disabled channels take the static level, enabled ones play
      bus_write(WPG_REG_CHAN_EN, 32'h0F);
      bus_write(WPG_REG_STATIC, 32'h50);
      #1;
      check({24'h0, wave}, 32'h5C);
      bus_write(WPG_REG_RUN, 32'h1);
      tick_check(12, 8'h55);
      wait_lvl(1'b0, 40);
      bus_write(WPG_REG_CHAN_EN, 32'hFF);
      // Continuous: wrap, toggle, cancel, stop at last frame
      bus_write(WPG_REG_DIV, 32'hD);
      bus_write(WPG_REG_FRAMES, 32'h3);
      bus_write(WPG_REG_CTRL, 32'h1);
      bus_write(WPG_REG_RUN, 32'h1);
      tick_check(12, pat[0]);
      tick_check(13, pat[1]);
      tick_check(13, pat[2]);
      tick_check(13, pat[0]);
      bus_write(WPG_REG_RUN, 32'h1);
      bus_write(WPG_REG_RUN, 32'h1);
      bus_read(WPG_REG_STATUS, d);
      check(d, 32'h0001_0001);
      bus_write(WPG_REG_RUN, 32'h1);
      bus_read(WPG_REG_STATUS, d);
      check(d, 32'h0001_0003);
      wait_lvl(1'b0, 200);
      check({24'h0, wave}, {24'h0, pat[2]});
      n = u_target.changes;
      repeat (60) @(posedge clk_in);
      check(u_target.changes, n);
      // Pin as trigger, then as clock gate
      bus_write(WPG_REG_FRAMES, 32'h1);
      bus_write(WPG_REG_CTRL, 32'h2);
      u_target.set_pin(1'b1);
      wait_lvl(1'b1, 10);
      wait_lvl(1'b0, 40);
      check({24'h0, wave}, {24'h0, pat[0]});
      u_target.set_pin(1'b0);
      bus_write(WPG_REG_FRAMES, 32'h2);
      bus_write(WPG_REG_CTRL, 32'h6);
      bus_write(WPG_REG_RUN, 32'h1);
      repeat (40) @(posedge clk_in);
      #1;
      check({23'h0, playing, wave}, {23'h0, 1'b1, pat[0]});
      u_target.set_pin(1'b1);
      wait_lvl(1'b0, 60);
      check({24'h0, wave}, {24'h0, pat[1]});
      u_target.set_pin(1'b0);
      // Pattern writes queue during play; the ninth waits for the stop
      bus_write(WPG_REG_CTRL, 32'h0);
      bus_write(WPG_REG_FRAMES, 32'h4);
      bus_write(WPG_REG_RUN, 32'h1);
      bus_write(WPG_REG_FRAMES, 32'h1);
      for (int i = 0; i < 9; i++) begin
         bus_write(12'h800 + 12'(i * 4), 32'h10 + i);
      end
      check({31'h0, playing}, 32'h0);
      check({24'h0, wave}, {24'h0, pat[3]});
      rd_check(WPG_REG_FRAMES, 32'h4);
      rd_check(12'h800, 32'h10);
      rd_check(12'h820, 32'h18);
      stop_test();
   end
endmodule : tb
